//--- rtl/lps_ctrl.sv
// low-power, management-entry and thermal-trip state controller
`timescale 1ns/1ps
// Function
// [RULE1] sleep request in halted-core state moves to sleep
// [RULE2] sleep gates all unit clocks; only the pll keeps running
// [RULE3] sleep ignores snoop requests and interrupt inputs
// [RULE4] sleep reacts only to reset, sleep release, bus clock removal; the code also leaves sleep for deep sleep on a deep-sleep request
// [RULE5] sleep release returns to halted-core, restarting bus and interrupt controller clocks
// [RULE6] deep-sleep request during sleep moves to deep sleep
// [RULE7] management interrupt is asynchronous; synchronised and accepted in any phase
// [RULE8] accepted management interrupt saves state, then enters management mode
// [RULE9] management mode issues acknowledge transaction, then runs the handler
// [RULE10] management interrupt held at reset release tristates all outputs
// [RULE11] clock stop request enters halted-core and issues stop-grant acknowledge
// [RULE12] halted-core stops core clocks, keeps bus and interrupt controller clocked
// [RULE13] halted-core keeps snooping and servicing interrupts
// [RULE14] clock stop release restarts all clocks and resumes execution
// [RULE15] clock stop request is asynchronous and never touches the bus clock
// [RULE16] thermal sensor over limit halts execution and asserts trip output; the code trips only from run, halted-core and handler states
// [RULE17] sleep request outside halted-core causes no state change
// [RULE18] thermal trip holds halt and trip output until next reset
module lps_ctrl (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sleep_request_n,
  input  wire logic       deep_sleep_request_n,
  input  wire logic       mgmt_interrupt_n,
  input  wire logic       clock_stop_request_n,
  input  wire logic       bus_clk_present,
  input  wire logic       thermal_over_limit,
  input  wire logic       snoop_req,
  input  wire logic       irq_req,
  input  wire logic       mgmt_handler_done,
  output logic [6:0]      unit_clk_en,
  output logic            pll_run,
  output logic            exec_enable,
  output logic            snoop_accept,
  output logic            irq_accept,
  output logic            state_save,
  output logic            management_mode,
  output logic            handler_start,
  output logic            ack_valid,
  output logic            ack_is_mgmt,
  output logic            in_sleep,
  output logic            in_deep_sleep,
  output logic            outputs_oe_n,
  output logic            thermal_trip_out_n
);

  lps_pkg::lps_state_t state_r;
  lps_pkg::lps_state_t state_nxt;
  logic [4:0] sync_w;
  logic       slp_w;
  logic       dslp_w;
  logic       mgmt_w;
  logic       stop_w;
  logic       therm_w;
  logic       mgmt_prev_r;
  logic       mgmt_pend_r;
  logic [2:0] rel_r;
  logic [6:0] gate_nxt;
  logic       tri_r;
  logic [3:0] save_cnt_r;
  logic       sg_go;
  logic       mg_go;

  // pins and the sensor are asynchronous: two flops before any logic [RULE7] [RULE15]
  // the sensor flag goes in inverted so the whole bank idles high after reset
  lps_sync #(.W(5)) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({sleep_request_n, deep_sleep_request_n, mgmt_interrupt_n,
                clock_stop_request_n, ~thermal_over_limit}),
    .sync_out (sync_w)
  );

  assign slp_w  = ~sync_w[4];
  assign dslp_w = ~sync_w[3];
  assign mgmt_w = ~sync_w[2];
  assign stop_w = ~sync_w[1];
  assign therm_w = ~sync_w[0];

  // clock enables wanted in each state
  // core units stop in halted-core; only the pll outlives sleep
  function automatic logic [6:0] gate_of(input lps_pkg::lps_state_t s);
    logic [6:0] g;
    g = lps_pkg::CLK_GATE_ALL_ON;
    case (s)
      lps_pkg::LPS_HALT: begin
        g = lps_pkg::CLK_GATE_HALT; // [RULE12]
      end
      lps_pkg::LPS_SLEEP: begin
        g = lps_pkg::CLK_GATE_SLEEP; // [RULE2]
      end
      lps_pkg::LPS_DEEP: begin
        g = lps_pkg::CLK_GATE_SLEEP;
      end
      lps_pkg::LPS_TRIP: begin
        g = lps_pkg::CLK_GATE_SLEEP; // [RULE16]
      end
      default: begin
        g = lps_pkg::CLK_GATE_ALL_ON; // [RULE5] [RULE14]
      end
    endcase
    return g;
  endfunction

  // bus unit snoops wherever its clock runs and no handler entry is in flight
  function automatic logic snoops_in(input lps_pkg::lps_state_t s);
    return (s == lps_pkg::LPS_RUN) || (s == lps_pkg::LPS_HALT) ||
           (s == lps_pkg::LPS_MGMT_RUN);
  endfunction

  // interrupts wait while a management handler owns the core
  function automatic logic irqs_in(input lps_pkg::lps_state_t s);
    return (s == lps_pkg::LPS_RUN) || (s == lps_pkg::LPS_HALT);
  endfunction

  // instruction execution states
  function automatic logic runs_in(input lps_pkg::lps_state_t s);
    return (s == lps_pkg::LPS_RUN) || (s == lps_pkg::LPS_MGMT_RUN);
  endfunction

  // management mode spans the acknowledge and the handler
  function automatic logic mgmt_in(input lps_pkg::lps_state_t s);
    return (s == lps_pkg::LPS_MGMT_ACK) || (s == lps_pkg::LPS_MGMT_RUN);
  endfunction

  // mode strap: the pin is read through the sync bank, which needs two edges
  // after release, so the strobe is delayed to match and still sees the first edge [RULE10]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rel_r <= 3'h1;
      tri_r <= 1'b0;
    end else begin
      rel_r <= {rel_r[1:0], 1'b0};
      if (rel_r[2]) begin
        tri_r <= mgmt_w; // [RULE10]
      end
    end
  end

  // falling-edge detect on the synchronised level, latched until taken [RULE7]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mgmt_prev_r <= 1'b0;
      mgmt_pend_r <= 1'b0;
    end else begin
      mgmt_prev_r <= mgmt_w;
      if (mgmt_w && !mgmt_prev_r) begin
        mgmt_pend_r <= 1'b1; // set wins over the clear [RULE7]
      end else if (state_r == lps_pkg::LPS_SAVE) begin
        mgmt_pend_r <= 1'b0;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lps_pkg::LPS_RUN: begin
        if (therm_w) begin
          state_nxt = lps_pkg::LPS_TRIP; // [RULE16]
        end else if (stop_w) begin
          state_nxt = lps_pkg::LPS_HALT; // [RULE11]
        end else if (mgmt_pend_r) begin
          state_nxt = lps_pkg::LPS_SAVE; // [RULE8]
        end
      end
      lps_pkg::LPS_HALT: begin
        if (therm_w) begin
          state_nxt = lps_pkg::LPS_TRIP;
        end else if (!stop_w) begin
          state_nxt = lps_pkg::LPS_RUN; // [RULE14]
        end else if (slp_w) begin
          state_nxt = lps_pkg::LPS_SLEEP; // [RULE1]
        end
      end
      lps_pkg::LPS_SLEEP: begin
        // snoops, interrupts and management requests are not looked at here [RULE3] [RULE4]
        if (dslp_w || !bus_clk_present) begin
          // a lost bus clock counts as a deep-sleep request [RULE4]
          state_nxt = lps_pkg::LPS_DEEP; // [RULE6]
        end else if (!slp_w) begin
          state_nxt = lps_pkg::LPS_HALT; // [RULE5]
        end
      end
      lps_pkg::LPS_DEEP: begin
        if (!dslp_w && bus_clk_present) begin
          state_nxt = lps_pkg::LPS_SLEEP;
        end
      end
      lps_pkg::LPS_SAVE: begin
        if (save_cnt_r == 4'h0) begin
          state_nxt = lps_pkg::LPS_MGMT_ACK; // [RULE8]
        end
      end
      lps_pkg::LPS_MGMT_ACK: begin
        state_nxt = lps_pkg::LPS_MGMT_RUN; // [RULE9]
      end
      lps_pkg::LPS_MGMT_RUN: begin
        if (therm_w) begin
          state_nxt = lps_pkg::LPS_TRIP;
        end else if (mgmt_handler_done) begin
          state_nxt = lps_pkg::LPS_RUN;
        end
      end
      lps_pkg::LPS_TRIP: begin
        state_nxt = lps_pkg::LPS_TRIP; // only reset leaves [RULE18]
      end
      default: begin
        state_nxt = lps_pkg::LPS_RUN;
      end
    endcase
    // sleep request elsewhere is simply not decoded [RULE17]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= lps_pkg::LPS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      save_cnt_r <= lps_pkg::SAVE_CNT_W;
    end else if (state_r == lps_pkg::LPS_SAVE) begin
      save_cnt_r <= save_cnt_r - 4'h1;
    end else begin
      save_cnt_r <= lps_pkg::SAVE_CNT_W;
    end
  end

  assign sg_go = (state_r == lps_pkg::LPS_RUN) && (state_nxt == lps_pkg::LPS_HALT); // [RULE11]
  assign mg_go = (state_r == lps_pkg::LPS_MGMT_ACK); // [RULE9]
  // enables follow the next state so the clocks stop on the same edge as the state
  assign gate_nxt = gate_of(state_nxt);

  lps_ack u_ack (
    .clk           (clk),
    .arst_n        (arst_n),
    .stop_grant_go (sg_go),
    .mgmt_go       (mg_go),
    .ack_valid     (ack_valid),
    .ack_is_mgmt   (ack_is_mgmt)
  );

  // clock gating, registered from the next state so it switches with the state [RULE2]
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unit_clk_en <= lps_pkg::CLK_GATE_ALL_ON;
      pll_run     <= 1'b1;
    end else begin
      unit_clk_en <= gate_nxt; // [RULE2] [RULE12] [RULE14]
      // pll stays up in sleep so wake needs no relock
      pll_run     <= (state_nxt != lps_pkg::LPS_DEEP); // [RULE2]
    end
  end

  // execution and request acceptance
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exec_enable  <= 1'b1;
      snoop_accept <= 1'b0;
      irq_accept   <= 1'b0;
    end else begin
      exec_enable  <= runs_in(state_nxt); // [RULE14] [RULE18]
      snoop_accept <= snoop_req && snoops_in(state_nxt); // [RULE3] [RULE13]
      irq_accept   <= irq_req && irqs_in(state_nxt); // [RULE3] [RULE13]
    end
  end

  // management entry and sleep status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_save      <= 1'b0;
      management_mode <= 1'b0;
      handler_start   <= 1'b0;
      in_sleep        <= 1'b0;
      in_deep_sleep   <= 1'b0;
    end else begin
      state_save      <= (state_nxt == lps_pkg::LPS_SAVE); // [RULE8]
      management_mode <= mgmt_in(state_nxt); // [RULE8]
      // the handler starts on the edge that sends the acknowledge [RULE9]
      handler_start   <= (state_r == lps_pkg::LPS_MGMT_ACK);
      in_sleep        <= (state_nxt == lps_pkg::LPS_SLEEP);
      in_deep_sleep   <= (state_nxt == lps_pkg::LPS_DEEP);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thermal_trip_out_n <= 1'b1;
      outputs_oe_n       <= 1'b0;
    end else begin
      // only reset leaves the trip state, so the pin stays low until then
      thermal_trip_out_n <= ~(state_nxt == lps_pkg::LPS_TRIP); // [RULE16] [RULE18]
      outputs_oe_n       <= tri_r || (rel_r[2] && mgmt_w); // [RULE10]
    end
  end

endmodule

//--- rtl/lps_pkg.sv
// package: states, timing and reset constants for the low-power state controller
package lps_pkg;

  typedef enum logic [2:0] {
    LPS_RUN      = 3'b000,
    LPS_HALT     = 3'b001,
    LPS_SLEEP    = 3'b010,
    LPS_DEEP     = 3'b011,
    LPS_SAVE     = 3'b100,
    LPS_MGMT_ACK = 3'b101,
    LPS_MGMT_RUN = 3'b110,
    LPS_TRIP     = 3'b111
  } lps_state_t;

  localparam int CLK_PERIOD_PS      = 5000;
  // state save: printed time absent, chosen figure in ns
  localparam int SAVE_TIME_NS       = 40;
  localparam int SAVE_CYCLES        = (SAVE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] SAVE_CNT_W = 4'(SAVE_CYCLES);
  localparam int SYNC_STAGES        = 2;
  localparam logic SYNC_RESET_VAL   = 1'b1;
  localparam logic [6:0] CLK_GATE_ALL_ON  = 7'h7f;
  localparam logic [6:0] CLK_GATE_HALT    = 7'h03;
  localparam logic [6:0] CLK_GATE_SLEEP   = 7'h00;
  localparam int CG_BUS  = 0;
  localparam int CG_LIC  = 1;

endpackage

//--- rtl/lps_sync.sv
// two-flop synchroniser bank for asynchronous sideband inputs
`timescale 1ns/1ps
module lps_sync #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r   <= {W{lps_pkg::SYNC_RESET_VAL}};
      sync_out <= {W{lps_pkg::SYNC_RESET_VAL}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- rtl/lps_ack.sv
// one-shot acknowledge transaction issuer towards the system bus unit
`timescale 1ns/1ps
module lps_ack (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic stop_grant_go,
  input  wire logic mgmt_go,
  output logic      ack_valid,
  output logic      ack_is_mgmt
);

  // one cycle per request; stop-grant wins if both coincide (never happens)
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_valid   <= 1'b0;
      ack_is_mgmt <= 1'b0;
    end else begin
      ack_valid   <= stop_grant_go | mgmt_go;
      ack_is_mgmt <= mgmt_go & ~stop_grant_go;
    end
  end

endmodule

//--- dv/lps_ctrl_sva.sv
// checker: port-level properties of the low-power state controller
`timescale 1ns/1ps
module lps_ctrl_sva (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [6:0] unit_clk_en,
  input wire logic       pll_run,
  input wire logic       exec_enable,
  input wire logic       snoop_accept,
  input wire logic       irq_accept,
  input wire logic       state_save,
  input wire logic       management_mode,
  input wire logic       handler_start,
  input wire logic       ack_valid,
  input wire logic       ack_is_mgmt,
  input wire logic       in_sleep,
  input wire logic       in_deep_sleep,
  input wire logic       thermal_trip_out_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_halt_entry;
    $past(unit_clk_en) == 7'h7f && unit_clk_en == 7'h03;
  endsequence
  sequence s_save_end;
    $fell(state_save);
  endsequence
  a_halt_core_gate: assert property (unit_clk_en == 7'h03 |-> !exec_enable && pll_run)
    else $error("halted-core clocks or execution wrong");
  a_halt_ack_issued: assert property (s_halt_entry |-> ack_valid && !ack_is_mgmt)
    else $error("stop-grant acknowledge missing");
  a_sleep_clk_gate: assert property (in_sleep |-> unit_clk_en == 7'h00 && pll_run)
    else $error("sleep clock gating wrong");
  // accepts are registered, so allow the entry cycle to pass
  a_sleep_deaf: assert property (in_sleep && $past(in_sleep) |-> !snoop_accept && !irq_accept)
    else $error("request accepted in sleep");
  a_save_then_mode: assert property (s_save_end |-> management_mode)
    else $error("save did not lead to management mode");
  a_mgmt_ack_sent: assert property ($rose(management_mode) |-> ##[0:3] (ack_valid && ack_is_mgmt))
    else $error("management acknowledge missing");
  a_sleep_exit_halt: assert property ($fell(in_sleep) && !in_deep_sleep |-> unit_clk_en == 7'h03)
    else $error("sleep exit not to halted-core");
  a_deep_from_sleep: assert property ($rose(in_deep_sleep) |-> $past(in_sleep) && !pll_run)
    else $error("deep sleep entered wrongly");
  a_trip_sticky: assert property (!thermal_trip_out_n |=> !thermal_trip_out_n && !exec_enable)
    else $error("thermal trip released or execution resumed");
  a_handler_after_ack: assert property (handler_start |-> ack_valid && ack_is_mgmt && management_mode && exec_enable)
    else $error("handler started without management acknowledge");
endmodule

//--- dv/lps_sys_model.sv
// partner: system logic driving the asynchronous sideband requests
`timescale 1ns/1ps
module lps_sys_model (
  input wire logic       clk,
  input wire logic [3:0] want,
  input wire logic [1:0] skew,
  output logic           clock_stop_request_n,
  output logic           sleep_request_n,
  output logic           deep_sleep_request_n,
  output logic           mgmt_interrupt_n
);
  initial {mgmt_interrupt_n, deep_sleep_request_n, sleep_request_n, clock_stop_request_n} = 4'hf;
  // pins move a varying fraction of a period after the edge, so no phase is favoured
  always @(posedge clk) begin
    {mgmt_interrupt_n, deep_sleep_request_n, sleep_request_n, clock_stop_request_n} <=
      #(1.0 * skew + 0.5) ~want;
  end
endmodule

//--- dv/lps_ctrl_bench.sv
// testbench: sideband request sequences for the state controller
`timescale 1ns/1ps
module lps_ctrl_bench;
  logic       clk, arst_n, bus_clk_present, thermal_over_limit;
  logic       snoop_req, irq_req, mgmt_handler_done;
  logic [3:0] want;
  logic [1:0] skew;
  logic [31:0] lf;
  wire        clock_stop_request_n, sleep_request_n, deep_sleep_request_n, mgmt_interrupt_n;
  logic [6:0] unit_clk_en;
  logic       pll_run, exec_enable, snoop_accept, irq_accept, state_save, management_mode;
  logic       handler_start, ack_valid, ack_is_mgmt, in_sleep, in_deep_sleep;
  logic       outputs_oe_n, thermal_trip_out_n;
  int         errors, tests_run, i;
  lps_sys_model i_sys (.clk, .want, .skew, .clock_stop_request_n, .sleep_request_n,
    .deep_sleep_request_n, .mgmt_interrupt_n);
  lps_ctrl i_dut (.clk, .arst_n, .sleep_request_n, .deep_sleep_request_n, .mgmt_interrupt_n,
    .clock_stop_request_n, .bus_clk_present, .thermal_over_limit, .snoop_req, .irq_req,
    .mgmt_handler_done, .unit_clk_en, .pll_run, .exec_enable, .snoop_accept, .irq_accept,
    .state_save, .management_mode, .handler_start, .ack_valid, .ack_is_mgmt, .in_sleep,
    .in_deep_sleep, .outputs_oe_n, .thermal_trip_out_n);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // request levels: bit0 stop, bit1 sleep, bit2 deep sleep, bit3 management
  task automatic go(input logic [3:0] w);
    lf = lfsr(lf);
    skew = lf[1:0];
    want = w;
    cyc(6);
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  initial begin
    {arst_n, want, skew, snoop_req, irq_req, mgmt_handler_done, thermal_over_limit} = '0;
    bus_clk_present = 1'b1;
    lf = 32'h13fc4320;
    errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    cyc(2);
    chk(unit_clk_en, 7'h7f);
    chk(7'(outputs_oe_n), 7'h00);
    go(4'b0010);
    chk(7'(in_sleep), 7'h00);
    go(4'b0000);
    go(4'b0001);
    chk(unit_clk_en, 7'h03);
    chk(7'(exec_enable), 7'h00);
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      {irq_req, snoop_req} = lf[1:0];
      cyc(3);
      chk(7'({irq_accept, snoop_accept}), 7'(lf[1:0]));
    end
    $display("test halt done");
    {irq_req, snoop_req} = 2'b11;
    go(4'b0011);
    chk({in_sleep, pll_run, unit_clk_en[4:0]}, 7'h60);
    chk(7'({irq_accept, snoop_accept}), 7'h00);
    go(4'b0111);
    chk(7'({in_deep_sleep, pll_run}), 7'h02);
    go(4'b0011);
    chk(7'(in_sleep), 7'h01);
    bus_clk_present = 1'b0;
    cyc(4);
    chk(7'(in_deep_sleep), 7'h01);
    bus_clk_present = 1'b1;
    go(4'b0011);
    go(4'b0001);
    chk(unit_clk_en, 7'h03);
    {irq_req, snoop_req} = 2'b00;
    go(4'b0000);
    chk(7'({unit_clk_en == 7'h7f, exec_enable}), 7'h03);
    $display("test sleep done");
    go(4'b1000);
    chk(7'(state_save), 7'h01);
    cyc(10);
    chk(7'({management_mode, exec_enable}), 7'h03);
    mgmt_handler_done = 1'b1;
    cyc(1);
    mgmt_handler_done = 1'b0;
    go(4'b0000);
    chk(7'(management_mode), 7'h00);
    $display("test management done");
    thermal_over_limit = 1'b1;
    cyc(6);
    chk(7'({thermal_trip_out_n, exec_enable}), 7'h00);
    thermal_over_limit = 1'b0;
    go(4'b0001);
    chk(7'({thermal_trip_out_n, unit_clk_en == 7'h00}), 7'h01);
    $display("test trip done");
    arst_n = 1'b0;
    want = 4'b1000;
    cyc(3);
    arst_n = 1'b1;
    cyc(3);
    chk(7'({outputs_oe_n, thermal_trip_out_n}), 7'h03);
    $display("test tristate done");
    end_sim();
  end
endmodule
bind lps_ctrl lps_ctrl_sva i_sva (.clk, .arst_n, .unit_clk_en, .pll_run, .exec_enable,
  .snoop_accept, .irq_accept, .state_save, .management_mode, .handler_start, .ack_valid,
  .ack_is_mgmt,
  .in_sleep, .in_deep_sleep, .thermal_trip_out_n);
